// >>> cwd_config_decode.sv
// configuration word decode and identification register bank with apb slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "cwd_params.svh"
module cwd_config_decode
    import cwd_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3C, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h1, // arbitrary value
    parameter logic [119:0] SERIAL_ID = 120'h0123456789ABCDEF0123456789ABCD // arbitrary
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // partition swap request from the core
    input wire logic partition_swap_instr,
    output logic swap_refused,
    // decoded configuration
    output cwd_decode_type decode,
    output logic [15:0] wdt_ratio
);
    localparam int UIDW = 24;
    logic [23:0] wdt_cfg_ff;
    logic [23:0] por_cfg_ff;
    logic [23:0] dbg_cfg_ff;
    logic [23:0] opt_cfg_ff;
    logic [3:0] prog_done_ff;
    logic [3:0] run_ctrl_ff;
    logic swap_refused_ff;
    cwd_decode_type decode_ff;
    cwd_decode_type nxt_decode;
    logic [15:0] wdt_ratio_ff;
    logic [31:0] nxt_rdata;
    logic addr_ok;
    logic [23:0] uid_word [5];

    wire logic wr_xfer = psel && penable && pwrite;
    wire logic rd_setup = psel && !penable && !pwrite;

    // serial words come from parameters only: no write or erase path reaches them
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_uid
            assign uid_word[gi] = SERIAL_ID[gi*UIDW +: UIDW];
        end
    endgenerate

    // program-once configuration words; erased state is all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cfg_ff <= `CWD_CFG_ERASED;
            por_cfg_ff <= `CWD_CFG_ERASED;
            dbg_cfg_ff <= `CWD_CFG_ERASED;
            opt_cfg_ff <= `CWD_CFG_ERASED;
            prog_done_ff <= 4'h0;
        end else if (wr_xfer && pstrb[0]) begin
            // a second write to a word is ignored; unimplemented bits forced to one
            if (paddr == `CWD_ADDR_WDT && !prog_done_ff[0]) begin
                wdt_cfg_ff <= pwdata[23:0] | ~`CWD_WDT_MASK;
                prog_done_ff[0] <= 1'b1;
            end
            if (paddr == `CWD_ADDR_POR && !prog_done_ff[1]) begin
                por_cfg_ff <= pwdata[23:0] | ~`CWD_POR_MASK;
                prog_done_ff[1] <= 1'b1;
            end
            if (paddr == `CWD_ADDR_DBG && !prog_done_ff[2]) begin
                // reserved bit 7 is the programmer's duty; kept as written
                dbg_cfg_ff <= pwdata[23:0] | ~`CWD_DBG_MASK;
                prog_done_ff[2] <= 1'b1;
            end
            if (paddr == `CWD_ADDR_OPT && !prog_done_ff[3]) begin
                opt_cfg_ff <= pwdata[23:0] | ~`CWD_OPT_MASK;
                prog_done_ff[3] <= 1'b1;
            end
        end
    end

    // run-time control: bit0 retention enable, bit1 brown-out soft enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ctrl_ff <= 4'h0;
        end else if (wr_xfer && pstrb[0] && paddr == `CWD_ADDR_CTRL) begin
            run_ctrl_ff <= pwdata[3:0];
        end
    end

    // field decode from the stored words
    always_comb begin
        nxt_decode = '0;
        nxt_decode.wdt_ratio_log2 = 16'(wdt_cfg_ff[`CWD_WDT_PS_LSB +: 4]);
        nxt_decode.downside_protect_en = por_cfg_ff[`CWD_POR_DNVP_BIT];
        nxt_decode.retention_avail = !por_cfg_ff[`CWD_POR_LOW_POWER_REG_CFG_BIT] && run_ctrl_ff[0];
        nxt_decode.bor_mode = cwd_bor_type'(por_cfg_ff[`CWD_POR_BOR_LSB +: 2]);
        case (nxt_decode.bor_mode)
            CWD_BOR_ALWAYS: nxt_decode.bor_enabled = 1'b1;
            CWD_BOR_ACTIVE: nxt_decode.bor_enabled = 1'b1;
            CWD_BOR_SOFT: nxt_decode.bor_enabled = run_ctrl_ff[1];
            default: nxt_decode.bor_enabled = 1'b0;
        endcase
        nxt_decode.swap_allowed = !dbg_cfg_ff[`CWD_DBG_SWAP_BIT];
        nxt_decode.test_port_enable = dbg_cfg_ff[`CWD_DBG_JTAG_BIT];
        nxt_decode.debug_channel = cwd_dbg_type'(dbg_cfg_ff[`CWD_DBG_ICS_LSB +: 2]);
        nxt_decode.alt_reference_location = opt_cfg_ff[`CWD_OPT_VREF_BIT];
        nxt_decode.second_osc_high_drive = opt_cfg_ff[`CWD_OPT_SECONDARY_OSCILLATOR_BIT];
        nxt_decode.tamper_pin_enabled = !opt_cfg_ff[`CWD_OPT_TMPR_BIT];
        nxt_decode.alt_comparator_input = opt_cfg_ff[`CWD_OPT_CMP_BIT];
    end

    // decoded outputs refresh every cycle from the stored words, programmed or not;
    // once programmed, words never change, so outputs stay stable except retention and soft brown-out enable, which follow run_ctrl_ff
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decode_ff <= '0;
            wdt_ratio_ff <= 16'h0001;
        end else begin
            decode_ff <= nxt_decode;
            wdt_ratio_ff <= 16'h0001 << wdt_cfg_ff[`CWD_WDT_PS_LSB +: 4];
        end
    end
    assign decode = decode_ff;
    assign wdt_ratio = wdt_ratio_ff;

    // swap request refused by configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swap_refused_ff <= 1'b0;
        end else begin
            swap_refused_ff <= partition_swap_instr && !decode_ff.swap_allowed;
        end
    end
    assign swap_refused = swap_refused_ff;

    // read mux
    always_comb begin
        nxt_rdata = 32'h00000000;
        addr_ok = 1'b1;
        case (paddr)
            `CWD_ADDR_UID1: nxt_rdata = {8'h00, uid_word[0]};
            `CWD_ADDR_UID2: nxt_rdata = {8'h00, uid_word[1]};
            `CWD_ADDR_UID3: nxt_rdata = {8'h00, uid_word[2]};
            `CWD_ADDR_UID4: nxt_rdata = {8'h00, uid_word[3]};
            `CWD_ADDR_UID5: nxt_rdata = {8'h00, uid_word[4]};
            `CWD_ADDR_PART: nxt_rdata = {16'h0000, FAMILY_CODE, PART_CODE};
            `CWD_ADDR_REV: nxt_rdata = {28'h0000000, REVISION_CODE};
            `CWD_ADDR_WDT: nxt_rdata = {8'h00, wdt_cfg_ff};
            `CWD_ADDR_POR: nxt_rdata = {8'h00, por_cfg_ff};
            `CWD_ADDR_DBG: nxt_rdata = {8'h00, dbg_cfg_ff};
            `CWD_ADDR_OPT: nxt_rdata = {8'h00, opt_cfg_ff};
            `CWD_ADDR_CTRL: nxt_rdata = {28'h0000000, run_ctrl_ff};
            `CWD_ADDR_STAT: nxt_rdata = {28'h0000000, prog_done_ff};
            default: addr_ok = 1'b0;
        endcase
    end

    // read data captured in setup phase; one access cycle always
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= nxt_rdata;
        end
    end

    // error: unmapped address, or write to a read-only word
    wire logic ro_addr = (paddr == `CWD_ADDR_PART) || (paddr == `CWD_ADDR_REV) ||
        (paddr[31:8] == 24'(`CWD_ADDR_UID1 >> 8) && paddr[7:0] <= 8'h20);
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_ok || (pwrite && ro_addr));

    // assertions: many check a decoded field one cycle behind its stored word;
    // the presetn antecedent keeps an attempt that starts on the release edge
    // quiet, since the decode flops still show their reset values one edge later

    // cycles since the postscale word was programmed; saturates, so it never wraps
    logic [7:0] hold_cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_ff <= 8'h00;
        end else if (prog_done_ff[0] && hold_cnt_ff != 8'hFF) begin
            hold_cnt_ff <= hold_cnt_ff + 8'h01;
        end
    end

    // watchdog postscale ratio: one set bit, at the position the code selects;
    // two cycles after programming the ratio must not move any more
    ratio_pow_a: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(wdt_cfg_ff) ##1 $stable(wdt_cfg_ff) |->
        wdt_ratio == (16'h0001 << decode.wdt_ratio_log2[3:0]))
        else $error("watchdog ratio mismatch");

    ratio_log2_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.wdt_ratio_log2 == 16'($past(wdt_cfg_ff[`CWD_WDT_PS_LSB +: 4])))
        else $error("watchdog ratio code mismatch");

    ratio_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(wdt_ratio))
        else $error("watchdog ratio not a power of two");

    ratio_held_a: assert property (@(posedge pclk) disable iff (!presetn)
        hold_cnt_ff >= 8'h02 |-> $stable(wdt_ratio))
        else $error("watchdog ratio moved after programming");

    // power-on word: downside protection, retention gate and brown-out mode;
    // retention and soft brown-out also follow the run-time control bits
    dnvp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.downside_protect_en == $past(por_cfg_ff[`CWD_POR_DNVP_BIT]))
        else $error("downside protection mismatch");

    ret_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        por_cfg_ff[`CWD_POR_LOW_POWER_REG_CFG_BIT] && $stable(por_cfg_ff) |=> !decode.retention_avail)
        else $error("retention available with regulator bit set");

    ret_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.retention_avail ==
        (!$past(por_cfg_ff[`CWD_POR_LOW_POWER_REG_CFG_BIT]) && $past(run_ctrl_ff[0])))
        else $error("retention gating mismatch");

    bor_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        decode.bor_mode == CWD_BOR_OFF |-> !decode.bor_enabled)
        else $error("brown-out enabled in disabled mode");

    bor_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        decode.bor_mode == CWD_BOR_ALWAYS |-> decode.bor_enabled)
        else $error("brown-out off in always mode");

    bor_active_a: assert property (@(posedge pclk) disable iff (!presetn)
        decode.bor_mode == CWD_BOR_ACTIVE |-> decode.bor_enabled)
        else $error("brown-out off in active-only mode");

    bor_soft_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> (decode.bor_mode != CWD_BOR_SOFT ||
        decode.bor_enabled == $past(run_ctrl_ff[1])))
        else $error("brown-out ignores its software enable");

    // unimplemented positions read one in every word
    unimpl_wdt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wdt_cfg_ff | `CWD_WDT_MASK) == `CWD_CFG_ERASED)
        else $error("unimplemented watchdog bit read as zero");

    unimpl_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (por_cfg_ff | `CWD_POR_MASK) == `CWD_CFG_ERASED)
        else $error("unimplemented bit read as zero");

    unimpl_dbg_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dbg_cfg_ff | `CWD_DBG_MASK) == `CWD_CFG_ERASED)
        else $error("unimplemented debug bit read as zero");

    unimpl_opt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (opt_cfg_ff | `CWD_OPT_MASK) == `CWD_CFG_ERASED)
        else $error("unimplemented option bit read as zero");

    // program-once words freeze once their flag is set, and flags never fall
    // until reset; a second write must leave no trace anywhere
    once_wdt_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_done_ff[0] |=> $stable(wdt_cfg_ff))
        else $error("watchdog word changed after programming");

    once_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_done_ff[1] |=> $stable(por_cfg_ff))
        else $error("word changed after programming");

    once_dbg_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_done_ff[2] |=> $stable(dbg_cfg_ff))
        else $error("debug word changed after programming");

    once_opt_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_done_ff[3] |=> $stable(opt_cfg_ff))
        else $error("option word changed after programming");

    flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> (prog_done_ff & $past(prog_done_ff)) == $past(prog_done_ff))
        else $error("programmed flag cleared");

    // debug word: swap gate, test port and debug channel;
    // a swap request is refused exactly one cycle later, and only then
    swap_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.swap_allowed != $past(dbg_cfg_ff[`CWD_DBG_SWAP_BIT]))
        else $error("swap permission mismatch");

    swap_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        partition_swap_instr && dbg_cfg_ff[`CWD_DBG_SWAP_BIT] && !decode.swap_allowed
        |=> swap_refused)
        else $error("swap not refused");

    swap_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        !partition_swap_instr |=> !swap_refused)
        else $error("swap refused with no request");

    jtag_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.test_port_enable == $past(dbg_cfg_ff[`CWD_DBG_JTAG_BIT]))
        else $error("test port enable mismatch");

    dbg_chan_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> 2'(decode.debug_channel) == $past(dbg_cfg_ff[`CWD_DBG_ICS_LSB +: 2]))
        else $error("debug channel mismatch");

    // pin option word: each bit drives one routing, tamper pin enable or drive-strength choice
    vref_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.alt_reference_location == $past(opt_cfg_ff[`CWD_OPT_VREF_BIT]))
        else $error("reference location mismatch");

    osc_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.second_osc_high_drive == $past(opt_cfg_ff[`CWD_OPT_SECONDARY_OSCILLATOR_BIT]))
        else $error("oscillator drive mismatch");

    tamper_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.tamper_pin_enabled != $past(opt_cfg_ff[`CWD_OPT_TMPR_BIT]))
        else $error("tamper enable not inverted");

    cmp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> decode.alt_comparator_input == $past(opt_cfg_ff[`CWD_OPT_CMP_BIT]))
        else $error("comparator input mismatch");

    // identification and serial words: fixed contents, and a write is refused;
    // read data is captured in setup, so it is checked at the access edge
    id_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == `CWD_ADDR_PART |=> prdata[15:0] == {FAMILY_CODE, PART_CODE})
        else $error("identity word wrong");

    rev_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == `CWD_ADDR_REV |=> prdata == {28'h0000000, REVISION_CODE})
        else $error("revision word wrong");

    uid_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == `CWD_ADDR_UID1 |=> prdata == {8'h00, SERIAL_ID[23:0]})
        else $error("first serial word wrong");

    uid_last_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == `CWD_ADDR_UID5 |=> prdata == {8'h00, SERIAL_ID[119:96]})
        else $error("last serial word wrong");

    ro_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && ro_addr |-> pslverr)
        else $error("write to read-only word not refused");

    // main scenarios: programming, refusal, serial read, soft brown-out, bad write
    prog_por_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(prog_done_ff[1]));
    swap_ref_c: cover property (@(posedge pclk) disable iff (!presetn) swap_refused);
    uid_read_c: cover property (@(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == `CWD_ADDR_UID5);
    bor_soft_c: cover property (@(posedge pclk) disable iff (!presetn)
        decode.bor_mode == CWD_BOR_SOFT && decode.bor_enabled);
    ro_err_c: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && pslverr);
endmodule

// >>> cwd_params.svh
// constants for the configuration word decode block: offsets, fields, reset values
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH
// register byte offsets on the apb window (printed offsets are word indices)
`define CWD_IDX_UID1 24'h801600
`define CWD_IDX_UID2 24'h801602
`define CWD_IDX_UID3 24'h801604
`define CWD_IDX_UID4 24'h801606
`define CWD_IDX_UID5 24'h801608
`define CWD_IDX_PART 24'hFF0000
`define CWD_IDX_REV 24'hFF0002
`define CWD_ADDR_UID1 32'h02005800
`define CWD_ADDR_UID2 32'h02005808
`define CWD_ADDR_UID3 32'h02005810
`define CWD_ADDR_UID4 32'h02005818
`define CWD_ADDR_UID5 32'h02005820
`define CWD_ADDR_PART 32'h03FC0000
`define CWD_ADDR_REV 32'h03FC0008
`define CWD_ADDR_WDT 32'h00000100
`define CWD_ADDR_POR 32'h00000104
`define CWD_ADDR_DBG 32'h00000108
`define CWD_ADDR_OPT 32'h0000010C
`define CWD_ADDR_CTRL 32'h00000110
`define CWD_ADDR_STAT 32'h00000114
// configuration word geometry: erased words read all ones
`define CWD_CFG_ERASED 24'hFFFFFF
`define CWD_CFG_W 24
`define CWD_WDT_PS_LSB 0
`define CWD_POR_BOR_LSB 0
`define CWD_POR_LOW_POWER_REG_CFG_BIT 2
`define CWD_POR_DNVP_BIT 3
`define CWD_DBG_ICS_LSB 0
`define CWD_DBG_JTAG_BIT 5
`define CWD_DBG_RSVD_BIT 7
`define CWD_DBG_SWAP_BIT 15
`define CWD_OPT_CMP_BIT 1
`define CWD_OPT_TMPR_BIT 2
`define CWD_OPT_SECONDARY_OSCILLATOR_BIT 3
`define CWD_OPT_VREF_BIT 4
// implemented-bit masks per word; other positions read as one
`define CWD_WDT_MASK 24'h006BFF
`define CWD_POR_MASK 24'h00000F
`define CWD_DBG_MASK 24'h0080A3
`define CWD_OPT_MASK 24'h00001E
`define CWD_CTRL_RESET 32'h00000000
`endif

// >>> cwd_pkg.sv
// types shared by the configuration word decode block
package cwd_pkg;
    typedef enum logic [1:0] {
        CWD_BOR_OFF, CWD_BOR_SOFT, CWD_BOR_ACTIVE, CWD_BOR_ALWAYS
    } cwd_bor_type;
    typedef enum logic [1:0] {
        CWD_DBG_NONE, CWD_DBG_PAIR3, CWD_DBG_PAIR2, CWD_DBG_PAIR1
    } cwd_dbg_type;
    typedef struct packed {
        logic [15:0] wdt_ratio_log2;
        logic downside_protect_en;
        logic retention_avail;
        logic bor_enabled;
        cwd_bor_type bor_mode;
        logic swap_allowed;
        logic test_port_enable;
        cwd_dbg_type debug_channel;
        logic alt_reference_location;
        logic second_osc_high_drive;
        logic tamper_pin_enabled;
        logic alt_comparator_input;
    } cwd_decode_type;
endpackage

// >>> cwd_config_decode_tb.sv
// self-checking bench for the configuration word decode block
`timescale 1ns/1ns
`include "cwd_params.svh"
module cwd_config_decode_tb
    import cwd_pkg::*;
();
    localparam logic [119:0] SID = 120'h0F1E2D3C4B5A69788796A5B4C3D2E1; // arbitrary value
    // stimulus, all given a value at time zero
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic partition_swap_instr = 1'b0;
    // design outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic swap_refused;
    cwd_decode_type decode;
    logic [15:0] wdt_ratio;
    // bench state
    int n_mismatch = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic err;
    logic [3:0] c;
    logic [1:0] ics;
    logic [23:0] wd [4];
    logic [31:0] cfg_addr [4] = '{`CWD_ADDR_WDT, `CWD_ADDR_POR, `CWD_ADDR_DBG, `CWD_ADDR_OPT};
    logic [23:0] cfg_mask [4] = '{`CWD_WDT_MASK, `CWD_POR_MASK, `CWD_DBG_MASK, `CWD_OPT_MASK};
    cwd_bor_type bor_tab [4] = '{CWD_BOR_OFF, CWD_BOR_SOFT, CWD_BOR_ACTIVE, CWD_BOR_ALWAYS};
    cwd_dbg_type dbg_tab [4] = '{CWD_DBG_NONE, CWD_DBG_PAIR3, CWD_DBG_PAIR2, CWD_DBG_PAIR1};

    always #2 pclk = ~pclk;

    cwd_config_decode #(
        .FAMILY_CODE(8'h5A), // arbitrary value
        .PART_CODE(8'hC3), // arbitrary value
        .REVISION_CODE(4'h6), // arbitrary value
        .SERIAL_ID(SID)
    ) i_cwd_config_decode (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .partition_swap_instr(partition_swap_instr),
        .swap_refused(swap_refused), .decode(decode), .wdt_ratio(wdt_ratio)
    );

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] sb);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= sb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // every pass starts from erased words, since words program once per reset
    initial begin
        for (int n = 0; n < 16; n++) begin
            c = 4'(n);
            ics = (c[3:2] == 2'b00) ? 2'b11 : c[3:2];
            @(posedge pclk);
            presetn <= 1'b0;
            repeat (3) @(posedge pclk);
            presetn <= 1'b1;
            apb(1'b0, `CWD_ADDR_STAT, 32'h0, 4'h0);
            chk("stat erased", {28'h0, rd[3:0]}, 32'h0);
            for (int w = 0; w < 4; w++) begin
                apb(1'b0, cfg_addr[w], 32'h0, 4'h0);
                chk("erased word", rd, 32'h00FFFFFF);
            end
            chk("erased ratio", 32'(wdt_ratio), 32'h00008000);
            chk("erased bor", 32'(decode.bor_mode), 32'(CWD_BOR_ALWAYS));
            chk("erased dbg", 32'(decode.debug_channel), 32'(CWD_DBG_PAIR1));
            chk("erased swap", 32'(decode.swap_allowed), 32'h0);
            // a write with strobe low must leave the control register alone
            apb(1'b1, `CWD_ADDR_CTRL, 32'h3, 4'h0);
            apb(1'b0, `CWD_ADDR_CTRL, 32'h0, 4'h0);
            chk("ctrl strobe", rd, 32'h0);
            apb(1'b1, `CWD_ADDR_CTRL, {30'h0, c[3], c[0]}, 4'hF);
            apb(1'b0, `CWD_ADDR_CTRL, 32'h0, 4'h0);
            chk("ctrl", rd, {30'h0, c[3], c[0]});
            // zeros in unimplemented places, reserved debug bit kept at one
            wd[0] = {20'h0, c};
            wd[1] = {20'h0, c};
            wd[2] = {8'h0, c[0], 7'h0, 1'b1, 1'b0, c[1], 3'h0, ics};
            wd[3] = {19'h0, c, 1'b0};
            for (int w = 0; w < 4; w++) begin
                apb(1'b1, cfg_addr[w], {8'h0, wd[w]}, 4'hF);
                chk("prog err", 32'(err), 32'h0);
            end
            for (int w = 0; w < 4; w++) begin
                apb(1'b0, cfg_addr[w], 32'h0, 4'h0);
                chk("readback", rd, {8'h0, (wd[w] & cfg_mask[w]) | ~cfg_mask[w]});
            end
            repeat (2) @(posedge pclk);
            chk("ratio", 32'(wdt_ratio), 32'(16'h1 << c));
            chk("ratio code", 32'(decode.wdt_ratio_log2), 32'(c));
            chk("bor mode", 32'(decode.bor_mode), 32'(bor_tab[c[1:0]]));
            chk("bor on", 32'(decode.bor_enabled), 32'(c[1] | ((c[1:0] == 2'b01) & c[3])));
            chk("downside", 32'(decode.downside_protect_en), 32'(c[3]));
            chk("retention", 32'(decode.retention_avail), 32'({~c[2] & c[0]}));
            chk("swap ok", 32'(decode.swap_allowed), 32'({~c[0]}));
            chk("test port", 32'(decode.test_port_enable), 32'(c[1]));
            chk("dbg chan", 32'(decode.debug_channel), 32'(dbg_tab[ics]));
            chk("vref alt", 32'(decode.alt_reference_location), 32'(c[3]));
            chk("osc drive", 32'(decode.second_osc_high_drive), 32'(c[2]));
            chk("tamper", 32'(decode.tamper_pin_enabled), 32'({~c[1]}));
            chk("cmp input", 32'(decode.alt_comparator_input), 32'(c[0]));
            chk("swap idle", 32'(swap_refused), 32'h0);
            partition_swap_instr <= 1'b1;
            @(posedge pclk);
            partition_swap_instr <= 1'b0;
            @(posedge pclk);
            chk("swap refused", 32'(swap_refused), 32'(c[0]));
            // a second program attempt is ignored silently
            apb(1'b1, `CWD_ADDR_WDT, 32'h0, 4'hF);
            chk("reprog err", 32'(err), 32'h0);
            apb(1'b0, `CWD_ADDR_WDT, 32'h0, 4'h0);
            chk("reprog word", rd, {8'h0, (wd[0] & cfg_mask[0]) | ~cfg_mask[0]});
            repeat (2) @(posedge pclk);
            chk("ratio held", 32'(wdt_ratio), 32'(16'h1 << c));
            apb(1'b0, `CWD_ADDR_STAT, 32'h0, 4'h0);
            chk("stat prog", {28'h0, rd[3:0]}, 32'hF);
        end
        // identification words are read only; writes are refused
        apb(1'b1, `CWD_ADDR_PART, 32'h0000FFFF, 4'hF);
        chk("part wr err", 32'(err), 32'h1);
        apb(1'b0, `CWD_ADDR_PART, 32'h0, 4'h0);
        chk("part id", {16'h0, rd[15:0]}, 32'h00005AC3);
        apb(1'b0, `CWD_ADDR_REV, 32'h0, 4'h0);
        chk("revision", {28'h0, rd[3:0]}, 32'h6);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, `CWD_ADDR_UID1 + 32'(8 * k), 32'h0, 4'hF);
            chk("serial wr err", 32'(err), 32'h1);
            apb(1'b0, `CWD_ADDR_UID1 + 32'(8 * k), 32'h0, 4'h0);
            chk("serial", {8'h0, rd[23:0]}, {8'h0, SID[24 * k +: 24]});
        end
        apb(1'b0, 32'h00000200, 32'h0, 4'h0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        summarize();
    end

    // the sequence needs about twelve hundred cycles; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
endmodule
